// file: host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk_sys_in,
  output var  logic       start_out = 1'b0, stop_out = 1'b0,
  output var  logic       read_out = 1'b0, wr_out = 1'b0,
  output var  logic [7:0] addr_out = 8'h00
);
  // One bus event: START, STOP or byte; accesses always open with START
  task automatic op(input logic [2:0] s, input logic rd, input logic [7:0] a);
    @(negedge clk_sys_in);
    {start_out, stop_out, wr_out} = s;
    if (s[2]) read_out = rd;
    addr_out = a;
    @(negedge clk_sys_in);
    {start_out, stop_out, wr_out} = 3'b000;
    addr_out = ~a; // Stale address is scrambled
  endtask
endmodule // host_model
`default_nettype wire

// file: tac_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tac_sva #(parameter [23:0] TIMEOUT_CYC = 24'h000100) (
  input wire logic clk_sys_in, rst_n_in, tick_4096_in, bus_start_in,
  input wire logic bus_stop_in, bus_read_in, bus_wr_in, halt_bit_in,
  input wire logic external_event_input, event_sync_enable, tick_100hz_in,
  input wire logic freeze_out, sec_inc_out, hund_run_out, hund_clear_out,
  input wire logic presc_reset_out, bus_reset_out, read_fill_out,
  input wire logic [7:0] bus_addr_in, read_fill_data_out, addr_ptr_out,
  input wire logic [11:0] presc_out
);
  logic [23:0] frz_r;
  wire sec_wr = bus_wr_in && freeze_out && (bus_addr_in == 8'h01);
  wire wr_frz = freeze_out && !bus_read_in;
  // Frozen cycles since the last START
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
    if (!rst_n_in) frz_r <= 24'h000000;
    else frz_r <= (freeze_out && !bus_start_in) ? frz_r + 24'h1 : 24'h0;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  start_freeze_a: assert property (bus_start_in |=> freeze_out)
    else $error("no freeze");
  frozen_inc_a: assert property (freeze_out |-> !sec_inc_out)
    else $error("tick while frozen");
  stop_thaw_a: assert property (bus_stop_in && freeze_out |=> !freeze_out)
    else $error("freeze kept");
  sec_clear_a: assert property (sec_wr |-> ##[1:2] hund_clear_out)
    else $error("hundredths kept");
  sec_sync_a: assert property (sec_wr |-> ##[1:2] presc_reset_out)
    else $error("no resync");
  sync_phase_a: assert property (presc_reset_out |-> presc_out <= 12'h001)
    else $error("phase kept");
  time_limit_a: assert property (frz_r <= TIMEOUT_CYC + 24'h3)
    else $error("access too long");
  fill_data_a: assert property (read_fill_out |-> read_fill_data_out == 8'hFF)
    else $error("bad fill");
  ptr_keep_a: assert property (bus_reset_out && !$past(bus_wr_in)
    |-> addr_ptr_out == $past(addr_ptr_out)) else $error("pointer lost");
  read_hund_a: assert property (freeze_out && bus_read_in && tick_100hz_in
    |-> ##[0:2] hund_run_out) else $error("hundredths held");
  write_hund_a: assert property (wr_frz && !bus_start_in
    |=> !hund_run_out || !freeze_out) else $error("hundredths ran");
  cover property (presc_reset_out);
  cover property (sec_inc_out);
  cover property (bus_reset_out);
  cover property (read_fill_out);
endmodule // tac_sva
bind time_access_coherence tac_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (.*);
`default_nettype wire

// file: time_access_coherence.v
`timescale 1ns/1ps
`default_nettype none
`include "time_access_coherence_defines.vh"

// Operation
// - Freeze time counters during short accesses
// - Remember one tick, apply after STOP
// - Halt toggle, event, seconds write resync
// - Prescaler reset shortens period for consumers
// - STOP unfreezes and applies pending tick
// - Seconds write clears hundredths to 00
// - Write timeout resets bus, keeps time
// - Read timeout returns FFh, applies tick
// - Address pointer kept across stop, timeout
// - Hundredths keep running during reads
// - Write without seconds keeps phase, tick
// - Halt or event resync keeps seconds
module time_access_coherence #(
  parameter [23:0] TIMEOUT_CYC = `TAC_TIMEOUT_CYC
) (
  input  wire       clk_sys_in,
  input  wire       rst_n_in,
  input  wire       tick_4096_in,
  input  wire       bus_start_in,
  input  wire       bus_stop_in,
  input  wire       bus_read_in,
  input  wire       bus_wr_in,
  input  wire [7:0] bus_addr_in,
  input  wire       halt_bit_in,
  input  wire       external_event_input,
  input  wire       event_sync_enable,
  input  wire       tick_100hz_in,
  output reg        freeze_out,
  output reg        sec_inc_out,
  output reg        hund_run_out,
  output reg        hund_clear_out,
  output reg        presc_reset_out,
  output reg        bus_reset_out,
  output reg        read_fill_out,
  output reg  [7:0] read_fill_data_out,
  output reg  [11:0] presc_out,
  output reg  [7:0] addr_ptr_out
);

  // Access state
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_WRITE = 2'b01;
  localparam [1:0] ST_READ  = 2'b10;
  localparam [1:0] ST_TMO   = 2'b11;

  // How an access is handled
  //   IDLE  : no access; 1 Hz wraps go straight to the time counters
  //   WRITE : host is writing; time and hundredths are frozen
  //   READ  : host is reading; time frozen, hundredths keep running
  //   TMO   : access cut by the timeout; counting runs as in IDLE
  // A START enters WRITE or READ from any state unless a STOP or the
  // timeout wins in the same cycle, taking the direction from the read
  // level that comes with it; a repeated START may switch direction
  // without a STOP in between.
  // While frozen, at most one wrap of the prescaler is kept back and
  // issued as soon as the freeze ends, by STOP or by timeout.
  // Three events resynchronise the prescaler: a seconds write and a
  // halt bit written 0 then 1, both inside an access, and a rising
  // edge on the event input while event sync is enabled (this one
  // also acts outside an access). Each drops the kept-back wrap.
  // Output pulses (increment, clear, prescaler reset, bus reset) last
  // one cycle each and come from flip-flops, one cycle after the
  // input that causes them; a prescaler reset comes three cycles after the event input.
  // Hazard: a START and the timeout in the same cycle let the timeout
  // win, so that access is lost and the host must START again.
  // Limitation: the hundredths and seconds counters live outside this
  // block and only see the pulses made here; an access abandoned
  // without a STOP ends only by the timeout.

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [23:0] tmo_cnt_r;
  reg         pend_r;
  reg         halt_q_r;
  reg         halt_was_low_r;
  reg         tmo_read_r;
  reg         ev_s1_r;
  reg         ev_s2_r;
  reg         ev_s3_r;
  wire        ev_rise;
  wire        sec_wr;
  wire        halt_resync;
  wire        resync;
  wire        presc_wrap;
  wire        active;
  wire        timeout;
  wire        freezing;

  // Seconds lives at address 01h
  function is_seconds;
    input [7:0] a;
    begin
      is_seconds = (a == (`TAC_TIME_ADDR_LO + 8'h01));
    end
  endfunction

  // True for the two states in which an access holds the bus
  function is_access;
    input [1:0] st;
    begin
      is_access = (st == ST_WRITE) || (st == ST_READ);
    end
  endfunction

  // True for a read access
  function is_read;
    input [1:0] st;
    begin
      is_read = (st == ST_READ);
    end
  endfunction

  // Access decode, edge detect and the three resync sources
  assign active   = is_access(state_r);
  assign freezing = is_access(state_nxt);
  assign timeout  = active && (tmo_cnt_r >= TIMEOUT_CYC);
  assign ev_rise  = ev_s2_r & ~ev_s3_r;
  assign sec_wr   = bus_wr_in & is_seconds(bus_addr_in) & active;
  // Halt resync fires once, on the 0-to-1 return inside an access
  assign halt_resync = halt_bit_in & ~halt_q_r & halt_was_low_r &
                       active;
  assign resync   = sec_wr | halt_resync |
                    (ev_rise & event_sync_enable);
  assign presc_wrap = tick_4096_in && (presc_out == 12'hFFF);

  // Event input synchroniser
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ev_s1_r <= 1'b0;
      ev_s2_r <= 1'b0;
      ev_s3_r <= 1'b0;
    end else begin
      ev_s1_r <= external_event_input;
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
    end
  end

  // Access state sequencing
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (bus_start_in)
          state_nxt = bus_read_in ? ST_READ : ST_WRITE;
      end
      ST_WRITE, ST_READ: begin
        if (timeout)
          state_nxt = ST_TMO;
        else if (bus_stop_in)
          state_nxt = ST_IDLE;
        else if (bus_start_in)
          state_nxt = bus_read_in ? ST_READ : ST_WRITE;
      end
      ST_TMO: begin
        if (bus_start_in)
          state_nxt = bus_read_in ? ST_READ : ST_WRITE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Access state register
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Halt bit history: a low level seen inside the access arms the
  // 0-then-1 resync, the delayed copy turns the return to 1 into a
  // single pulse; leaving the access disarms it
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      halt_q_r       <= 1'b0;
      halt_was_low_r <= 1'b0;
    end else begin
      halt_q_r <= halt_bit_in;
      if (!active)
        halt_was_low_r <= 1'b0;
      else if (!halt_bit_in)
        halt_was_low_r <= 1'b1;
    end
  end

  // Access duration, measured from each START so that a repeated
  // START restarts it; the count parks once the limit is reached and
  // stays parked until the host opens a new access
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tmo_cnt_r <= 24'h000000;
    end else if (bus_start_in) begin
      tmo_cnt_r <= 24'h000000;
    end else if (active && !timeout) begin
      tmo_cnt_r <= tmo_cnt_r + 24'h000001;
    end
  end

  // Prescaler from 4096 Hz down to 1 Hz. A resync restarts the whole
  // chain, so calendar counting, clock output, timers, temperature
  // sampling and the event filter all see a shortened current period,
  // while the stored seconds value is left alone
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc_out       <= 12'h000;
      presc_reset_out <= 1'b0;
    end else begin
      if (resync)
        presc_out <= 12'h000;
      else if (tick_4096_in)
        presc_out <= presc_out + 12'h001;
      presc_reset_out <= resync;
    end
  end

  // Once-per-second tick. While the counters are frozen one wrap is
  // remembered and a second one merges into it; when the freeze ends,
  // by STOP or by timeout, the remembered or a fresh wrap is issued.
  // A resync throws the remembered tick away and beats a wrap in the
  // same cycle, so a seconds write never gains an extra second.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_r      <= 1'b0;
      sec_inc_out <= 1'b0;
    end else begin
      sec_inc_out <= 1'b0;
      if (resync) begin
        pend_r <= 1'b0;
      end else if (freezing) begin
        if (presc_wrap)
          pend_r <= 1'b1;
      end else if (pend_r || presc_wrap) begin
        sec_inc_out <= 1'b1;
        pend_r      <= 1'b0;
      end
    end
  end

  // Freeze mirrors the access state: up one cycle after START, down
  // one cycle after STOP or the timeout
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      freeze_out <= 1'b0;
    end else begin
      freeze_out <= freezing;
    end
  end

  // Hundredths keep counting through reads but hold during writes;
  // a seconds write clears them
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hund_run_out   <= 1'b0;
      hund_clear_out <= 1'b0;
    end else begin
      hund_run_out   <= tick_100hz_in &&
                        (state_nxt != ST_WRITE);
      hund_clear_out <= sec_wr;
    end
  end

  // Timeout: reset the bus interface for one cycle and keep time as it
  // was. A cut read leaves every further byte reading as all ones
  // until the host opens a fresh access with START.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_reset_out      <= 1'b0;
      tmo_read_r         <= 1'b0;
      read_fill_out      <= 1'b0;
      read_fill_data_out <= 8'h00;
    end else begin
      bus_reset_out <= timeout;
      if (timeout)
        tmo_read_r <= is_read(state_r);
      else if (bus_start_in)
        tmo_read_r <= 1'b0;
      if (timeout)
        read_fill_out <= is_read(state_r);
      else if (bus_start_in)
        read_fill_out <= 1'b0;
      else
        read_fill_out <= tmo_read_r;
      read_fill_data_out <= `TAC_READ_FILL;
    end
  end

  // Register pointer: moved only by written address bytes inside an
  // access, so neither STOP nor the forced stop after a timeout
  // disturbs it
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_ptr_out <= 8'h00;
    end else if (bus_wr_in && active) begin
      addr_ptr_out <= bus_addr_in;
    end
  end

endmodule // time_access_coherence
`default_nettype wire

// file: time_access_coherence_defines.vh
`ifndef TIME_ACCESS_COHERENCE_DEFINES_VH
`define TIME_ACCESS_COHERENCE_DEFINES_VH

// Clock rate in hertz (100 ns period)
`define TAC_CLK_HZ          10000000
// Longest bus access before the internal timeout, in milliseconds
`define TAC_TIMEOUT_MS      950
// Timeout in clock cycles, 950 ms at 10 MHz, sized for the 24-bit count
`define TAC_TIMEOUT_CYC     24'h90F560
// Counter width for the timeout measurement
`define TAC_TMO_W           24
// Prescaler stages from 4096 Hz down to 1 Hz
`define TAC_PRESC_W         12
// Bytes read after a read timeout
`define TAC_READ_FILL       8'hFF
// Hundredths reset value after a seconds write
`define TAC_HUND_CLEAR      8'h00
// Time counter address range
`define TAC_TIME_ADDR_LO    8'h00
`define TAC_TIME_ADDR_HI    8'h07

`endif

// file: time_access_coherence_tb.sv
`timescale 1ns/1ps
`default_nettype none
module time_access_coherence_tb;
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, tick_4096_in = 1'b0;
  logic halt_bit_in = 1'b1, external_event_input = 1'b0;
  logic event_sync_enable = 1'b0, tick_100hz_in = 1'b0;
  wire bus_start_in, bus_stop_in, bus_read_in, bus_wr_in, freeze_out;
  wire sec_inc_out, hund_run_out, hund_clear_out, presc_reset_out;
  wire bus_reset_out, read_fill_out;
  wire [7:0] bus_addr_in, read_fill_data_out, addr_ptr_out;
  wire [11:0] presc_out;
  int n_errors = 0, check_count = 0;
  logic [7:0] n_inc, n_clr, n_prs, n_brst;
  // Row: read write halt event enable | inc clear sync | address
  logic [15:0] rows [6] = '{16'h4400, 16'h4301, 16'h8400,
                            16'h2100, 16'h1900, 16'h1400};
  always #50 clk_sys_in = ~clk_sys_in;
  always @(negedge clk_sys_in) tick_100hz_in <= ~tick_100hz_in;
  // Pulse counters for the check windows
  always @(posedge clk_sys_in) begin
    n_inc += sec_inc_out;
    n_clr += hund_clear_out;
    n_prs += presc_reset_out;
    n_brst += bus_reset_out;
  end
  host_model host_u (.clk_sys_in, .start_out(bus_start_in),
    .stop_out(bus_stop_in), .read_out(bus_read_in), .wr_out(bus_wr_in),
    .addr_out(bus_addr_in));
  time_access_coherence #(.TIMEOUT_CYC(24'h002328)) dut_u (.*);
  task automatic chk(input string nm, input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic summarize;
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Two or more prescaler wraps, then n quiet cycles
  task automatic spin(input int n);
    tick_4096_in = 1'b1;
    repeat (8200) @(negedge clk_sys_in);
    tick_4096_in = 1'b0;
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic run(input logic [15:0] r);
    host_u.op(3'b100, r[15], 8'h00);
    spin(0);
    n_inc = 0;
    n_clr = 0;
    n_prs = 0;
    if (r[14]) host_u.op(3'b001, r[15], r[7:0]);
    halt_bit_in = !r[13];
    @(negedge clk_sys_in);
    halt_bit_in = 1'b1;
    external_event_input = r[12];
    event_sync_enable = r[11];
    repeat (6) @(negedge clk_sys_in);
    chk("frozen", freeze_out, 8'h01);
    host_u.op(3'b010, r[15], 8'h00);
    repeat (4) @(negedge clk_sys_in);
    chk("inc", n_inc, r[10]);
    chk("clear", n_clr, r[9]);
    chk("sync", n_prs, r[8]);
    chk("freeze", freeze_out, 8'h00);
    external_event_input = 1'b0;
  endtask
  // Over-long access ended by the internal timeout
  task automatic tmo(input logic r);
    host_u.op(3'b100, r, 8'h00);
    if (!r) host_u.op(3'b001, r, 8'h05);
    n_inc = 0;
    n_brst = 0;
    spin(900);
    chk("timeout", n_brst, 8'h01);
    chk("tmo_inc", n_inc, 8'h01);
    chk("fill", read_fill_data_out, 8'hFF);
    chk("fill_on", read_fill_out, {7'h00, r});
  endtask
  initial begin
    #(100 * 90000);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (10) @(negedge clk_sys_in);
    chk("rst", {freeze_out, sec_inc_out, bus_reset_out, read_fill_out}, 8'h00);
    rst_n_in = 1'b1;
    foreach (rows[i]) run(rows[i]);
    tmo(1'b0);
    tmo(1'b1);
    chk("fill_on", read_fill_out, 8'h01);
    chk("ptr", addr_ptr_out, 8'h05);
    host_u.op(3'b100, 1'b0, 8'h00);
    chk("restart", {freeze_out, read_fill_out}, 8'h02);
    host_u.op(3'b010, 1'b0, 8'h00);
    summarize();
  end
endmodule // time_access_coherence_tb
`default_nettype wire
